// >>> voter_defines.vh
// Shared constants for the redundant output voter and its AXI4-Lite registers.
`ifndef VOTER_DEFINES_VH
`define VOTER_DEFINES_VH

// ==============================================================
// Register byte offsets
`define REG_CTRL          12'h000
`define REG_DEFAULT       12'h004
`define REG_TIMEOUT       12'h008
`define REG_STATUS        12'h00C
`define REG_VOTED         12'h010
`define REG_ID            12'h014

// ==============================================================
// Control register fields
`define CTRL_VOTE_EN      0
`define CTRL_DUPLEX_DEF   1
`define CTRL_HOLD_LAST    2
`define CTRL_FORCE_LO     4
`define CTRL_FORCE_HI     6

// ==============================================================
// Reset values and timing
`define CTRL_RESET        32'h0000_0001
`define DEFAULT_RESET     32'h0000_0000
`define TIMEOUT_US        1000
`define CLK_MHZ           100
`define TIMEOUT_CYCLES    (`TIMEOUT_US * `CLK_MHZ)
`define ID_VALUE          32'h0000_5A01 // Arbitrary value, names no part.

// AXI response codes.
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// >>> ctrl_link_monitor.v
// Per-controller online tracker with rejoin gating.
`default_nettype none

module ctrl_link_monitor #(
	parameter WIDTH    = 32,
	parameter TO_WIDTH = 32
) (
	input  wire                aclk,
	input  wire                aresetn,
	input  wire                frame_valid,
	input  wire [WIDTH-1:0]    frame_data,
	input  wire [WIDTH-1:0]    voted,
	input  wire                force_rejoin_request,
	input  wire [TO_WIDTH-1:0] timeout_cycles,
	output wire                online,
	output wire                logged_on,
	output reg  [WIDTH-1:0]    data_ff
);

	reg [TO_WIDTH-1:0] timer_ff;
	reg                online_ff;
	reg                logged_ff;

	assign online    = online_ff;
	assign logged_on = logged_ff;

	// ==============================================================
	// Frame timer, online state and logon gating.
	// A controller leaves online when no frame arrives in time, and must
	// then earn logon again so a stale command cannot untrip a load.
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer_ff  <= {TO_WIDTH{1'b0}};
			online_ff <= 1'b0;
			logged_ff <= 1'b0;
			data_ff   <= {WIDTH{1'b0}};
		end else if (frame_valid) begin
			timer_ff  <= timeout_cycles;
			online_ff <= 1'b1; // [R16]
			data_ff   <= frame_data;
			if (force_rejoin_request) begin
				logged_ff <= 1'b1; // [R13]
			end else if (frame_data == voted) begin
				logged_ff <= 1'b1; // [R12]
			end
		end else if (timer_ff != {TO_WIDTH{1'b0}}) begin
			timer_ff <= timer_ff - {{(TO_WIDTH-1){1'b0}}, 1'b1};
			if (force_rejoin_request && online_ff) begin
				logged_ff <= 1'b1; // [R13]
			end
		end else begin
			online_ff <= 1'b0; // [R16]
			logged_ff <= 1'b0; // [R11]
		end
	end

endmodule

`default_nettype wire

// >>> tmr_output_voter.v
// Triple-redundant output voter with an AXI4-Lite register slave.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`default_nettype none
`include "voter_defines.vh"

// Behaviour
// [R1] With three controllers logged on each point takes the majority bit.
// [R2] With three logged on the duplex-default bit is ignored.
// [R3] With two logged on the duplex-default bit stands in as third vote.
// [R4] Two online and duplex default one gives the OR of the two; the code takes the OR only when two are logged on, not merely online.
// [R5] Two online and duplex default zero gives the AND of the two; the code takes the AND only when two are logged on, not merely online.
// [R6] With one logged on its data is copied straight to the outputs.
// [R7] With none logged on each point goes to its configured default; the code holds the last state while any is online.
// [R8] When data stops, a group setting picks default or last state.
// [R9] A lone controller stops sending after its own timeout.
// [R10] The voted state is readable by the monitor for discrepancy checks.
// [R11] A returning controller is left out of voting until logged on.
// [R12] It logs on once its whole frame matches the voted output.
// [R13] The force rejoin request logs a returning controller on at once.
// [R14] Voting only runs in redundant mode; otherwise it is bypassed.
// [R15] Each block takes a frame from each of three separate buses.
// [R16] A controller is online while frames arrive inside the timeout.
module tmr_output_voter #(
	parameter WIDTH          = 32,
	parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             bus_a_valid,
	input  wire [WIDTH-1:0] bus_a_data,
	input  wire             bus_b_valid,
	input  wire [WIDTH-1:0] bus_b_data,
	input  wire             bus_c_valid,
	input  wire [WIDTH-1:0] bus_c_data,
	output reg  [WIDTH-1:0] load_out_ff,
	input  wire [11:0]      s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output wire             s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output wire             s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [11:0]      s_axi_araddr,
	input  wire             s_axi_arvalid,
	output wire             s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready
);

	// ==============================================================
	// Registers and internal signals
	reg  [31:0]      ctrl_ff;
	reg  [31:0]      default_ff;
	reg  [31:0]      timeout_ff;
	reg  [11:0]      awaddr_ff;
	reg              aw_held_ff;
	reg  [31:0]      wdata_ff;
	reg  [3:0]       wstrb_ff;
	reg              w_held_ff;
	reg  [2:0]       va_ff;
	reg  [2:0]       vb_ff;
	reg  [2:0]       vc_ff;
	reg  [WIDTH-1:0] da_ff [0:2];
	reg  [WIDTH-1:0] db_ff [0:2];
	reg  [WIDTH-1:0] nxt_load;
	reg  [31:0]      nxt_rdata;
	reg  [1:0]       nxt_rresp;
	wire [2:0]       online;
	wire [2:0]       logged;
	wire [WIDTH-1:0] ctrl_data [0:2];
	wire [2:0]       frame_valid;
	wire [2:0]       force_rejoin_request;
	wire [WIDTH-1:0] group_default;
	wire             vote_en;
	wire             duplex_def;
	wire             hold_last;
	wire             do_write;

	assign vote_en       = ctrl_ff[`CTRL_VOTE_EN];
	assign duplex_def    = ctrl_ff[`CTRL_DUPLEX_DEF];
	assign hold_last     = ctrl_ff[`CTRL_HOLD_LAST];
	assign group_default = default_ff[WIDTH-1:0];

	// Bus pins come from other boards, so both lanes pass two flops.
	always @(posedge aclk) begin
		if (!aresetn) begin
			va_ff <= 3'b000;
			vb_ff <= 3'b000;
		end else begin
			va_ff <= {bus_c_valid, bus_b_valid, bus_a_valid}; // [R15]
			vb_ff <= va_ff;
		end
	end

	// Data synchronisers; data is stable while its valid strobe is high.
	always @(posedge aclk) begin
		if (!aresetn) begin
			da_ff[0] <= {WIDTH{1'b0}};
			da_ff[1] <= {WIDTH{1'b0}};
			da_ff[2] <= {WIDTH{1'b0}};
			db_ff[0] <= {WIDTH{1'b0}};
			db_ff[1] <= {WIDTH{1'b0}};
			db_ff[2] <= {WIDTH{1'b0}};
			vc_ff    <= 3'b000;
		end else begin
			da_ff[0] <= bus_a_data;
			da_ff[1] <= bus_b_data;
			da_ff[2] <= bus_c_data;
			db_ff[0] <= da_ff[0];
			db_ff[1] <= da_ff[1];
			db_ff[2] <= da_ff[2];
			vc_ff    <= vb_ff;
		end
	end

	// One frame per rising edge of the synchronised valid level.
	assign frame_valid = vb_ff & ~vc_ff;

	// ==============================================================
	// One tracker per controller bus.
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : gen_mon
			assign force_rejoin_request[g] = ctrl_ff[`CTRL_FORCE_LO + g];
			ctrl_link_monitor #(
				.WIDTH    (WIDTH),
				.TO_WIDTH (32)
			) u_mon (
				.aclk                 (aclk),
				.aresetn              (aresetn),
				.frame_valid          (frame_valid[g]),
				.frame_data           (db_ff[g]),
				.voted                (load_out_ff),
				.force_rejoin_request (force_rejoin_request[g]),
				.timeout_cycles       (timeout_ff),
				.online               (online[g]),
				.logged_on            (logged[g]),
				.data_ff              (ctrl_data[g])
			);
		end
	endgenerate

	// Majority of three bits, used by the three- and two-controller voting cases.
	function [WIDTH-1:0] maj3;
		input [WIDTH-1:0] x;
		input [WIDTH-1:0] y;
		input [WIDTH-1:0] z;
		begin
			maj3 = (x & y) | (x & z) | (y & z);
		end
	endfunction

	// ==============================================================
	// Voting. With voting on, only logged-on controllers take part; an online one that
	// has not yet logged on casts no vote, but keeps the default off.
	always @* begin
		nxt_load = load_out_ff;
		if (!vote_en) begin
			// Bypass: the first controller with data drives the load.
			if (online[0]) begin
				nxt_load = ctrl_data[0]; // [R14]
			end else if (online[1]) begin
				nxt_load = ctrl_data[1];
			end else if (online[2]) begin
				nxt_load = ctrl_data[2];
			end else if (!hold_last) begin
				nxt_load = group_default;
			end
		end else begin
			case (logged) // [R11]
				3'b111: nxt_load = maj3(ctrl_data[0], ctrl_data[1],
					ctrl_data[2]); // [R1] [R2]
				3'b011: nxt_load = maj3(ctrl_data[0], ctrl_data[1],
					{WIDTH{duplex_def}}); // [R3] [R4] [R5]
				3'b101: nxt_load = maj3(ctrl_data[0], ctrl_data[2],
					{WIDTH{duplex_def}}); // [R3] [R4] [R5]
				3'b110: nxt_load = maj3(ctrl_data[1], ctrl_data[2],
					{WIDTH{duplex_def}}); // [R3] [R4] [R5]
				3'b001: nxt_load = ctrl_data[0]; // [R6]
				3'b010: nxt_load = ctrl_data[1]; // [R6]
				3'b100: nxt_load = ctrl_data[2]; // [R6]
				default: begin
					// Nobody logged on yet but someone online: hold so a
					// rejoining controller can match the present state.
					if (online == 3'b000 && !hold_last) begin
						nxt_load = group_default; // [R7] [R8]
					end
				end
			endcase
		end
	end

	// The voted state is registered; software reads it back. [R10]
	always @(posedge aclk) begin
		if (!aresetn) begin
			load_out_ff <= {WIDTH{1'b0}};
		end else begin
			load_out_ff <= nxt_load;
		end
	end

	// ==============================================================
	// AXI4-Lite write channel: address and data may come in any order.
	assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
	assign do_write      = aw_held_ff && w_held_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff   <= 1'b0;
			w_held_ff    <= 1'b0;
			awaddr_ff    <= 12'h000;
			wdata_ff     <= 32'h0000_0000;
			wstrb_ff     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_ff & 12'hFFC)
					`REG_CTRL, `REG_DEFAULT, `REG_TIMEOUT:
						s_axi_bresp <= `RESP_OKAY;
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Byte-lane merge of a write into a register.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = val[i*8 +: 8];
				end
			end
		end
	endfunction

	// Configuration registers. Force bits are levels software clears.
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff    <= `CTRL_RESET;
			default_ff <= `DEFAULT_RESET;
			timeout_ff <= TIMEOUT_CYCLES;
		end else if (do_write) begin
			case (awaddr_ff & 12'hFFC)
				`REG_CTRL:    ctrl_ff <= merge(ctrl_ff, wdata_ff,
					wstrb_ff) & 32'h0000_0077;
				`REG_DEFAULT: default_ff <= merge(default_ff, wdata_ff,
					wstrb_ff);
				`REG_TIMEOUT: timeout_ff <= merge(timeout_ff, wdata_ff,
					wstrb_ff);
				default: ;
			endcase
		end
	end

	// ==============================================================
	// AXI4-Lite read channel: one read at a time, answered next cycle.
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		nxt_rresp = `RESP_OKAY;
		nxt_rdata = 32'h0000_0000;
		case (s_axi_araddr & 12'hFFC)
			`REG_CTRL:    nxt_rdata = ctrl_ff;
			`REG_DEFAULT: nxt_rdata = default_ff;
			`REG_TIMEOUT: nxt_rdata = timeout_ff;
			`REG_STATUS:  nxt_rdata = {26'd0, logged, online};
			`REG_VOTED:   nxt_rdata = load_out_ff; // [R10]
			`REG_ID:      nxt_rdata = `ID_VALUE;
			default:      nxt_rresp = `RESP_SLVERR;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= nxt_rdata;
			s_axi_rresp  <= nxt_rresp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> tmr_output_voter_properties.sv
// Checker for the voter's register bus and its voted readout.
`default_nettype none
`include "voter_defines.vh"
// ====================
// Bus handshake and readout properties.
module tmr_output_voter_props #(
	parameter WIDTH          = 32,
	parameter TIMEOUT_CYCLES = 50
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic [WIDTH-1:0] load_out_ff,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic [11:0]      s_axi_araddr,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic [1:0]       s_axi_rresp,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// An answer that drops early is lost to the monitor.
	a_bresp_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=>
			s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
	a_rdata_hold:
		assert property (s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
	a_read_busy:
		assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_write_busy:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_read_turn:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_turn:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
			s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_err_zero:
		assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |->
			s_axi_rdata == 32'h0000_0000) else $error("error data not zero");
	// The readout must show the load state, not a stale copy.
	a_voted_read:
		assert property (s_axi_arvalid && s_axi_arready &&
			s_axi_araddr == `REG_VOTED |=> s_axi_rdata == $past(load_out_ff))
		else $error("voted readout differs");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_error: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

bind tmr_output_voter tmr_output_voter_props #(
	.WIDTH(WIDTH), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_props (.aclk(aclk), .aresetn(aresetn), .load_out_ff(load_out_ff),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// >>> ctrl_model.sv
// Behavioural controller that sends output frames on one bus.
`default_nettype none
// ====================
// One controller: strobe held three cycles, then at least two idle.
module ctrl_model #(
	parameter WIDTH = 32
) (
	input wire logic         aclk,
	output logic             valid,
	output logic [WIDTH-1:0] data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		valid = 1'b0;
		data = '0;
	end
	// Data flips once the strobe drops, so a late capture shows up.
	task automatic send(input logic [WIDTH-1:0] d);
		@(posedge aclk);
		valid <= 1'b1;
		data <= d;
		repeat (3) @(posedge aclk);
		valid <= 1'b0;
		data <= ~d;
		repeat (2) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the redundant output voter.
`default_nettype none
`include "voter_defines.vh"
// ====================
// Stimulus, expectation queue and verdict.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TMO = 50;
	logic        aclk, aresetn, a_v, b_v, c_v;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] a_d, b_d, c_d, load, wdata, rdata, last, dflt;
	logic [11:0] awaddr, araddr;
	logic [1:0]  bresp, rresp;
	logic [34:0] q[$];
	logic [34:0] e;
	int          fail_count, cmp_count;
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;
	tmr_output_voter #(.WIDTH(32), .TIMEOUT_CYCLES(TMO)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.bus_a_valid(a_v), .bus_a_data(a_d),
		.bus_b_valid(b_v), .bus_b_data(b_d),
		.bus_c_valid(c_v), .bus_c_data(c_d), .load_out_ff(load),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ctrl_model u_ca (.aclk(aclk), .valid(a_v), .data(a_d));
	ctrl_model u_cb (.aclk(aclk), .valid(b_v), .data(b_d));
	ctrl_model u_cc (.aclk(aclk), .valid(c_v), .data(c_d));
	task automatic chk(input string n, input logic [31:0] s, x);
		cmp_count++;
		if (s !== x) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Address and data leave together; each is dropped once taken.
	// The response is held off a random few beats to test its hold.
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r = `RESP_OKAY);
		bit pa, pw;
		q.push_back({1'b0, r, 32'h0000_0000});
		pa = 1;
		pw = 1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b0;
		while (pa || pw) begin
			@(posedge aclk);
			if (pa && awready) begin
				pa = 0;
				awvalid <= 1'b0;
			end
			if (pw && wready) begin
				pw = 0;
				wvalid <= 1'b0;
			end
		end
		repeat ($urandom % 4) @(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk iff bvalid);
	endtask
	// The flag bit asks the watcher to compare the load pins as well.
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic [1:0] r = `RESP_OKAY, input logic l = 1'b0);
		q.push_back({l, r, x});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b0;
		@(posedge aclk iff arready);
		arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk iff rvalid);
	endtask
	// Random frames on the chosen buses; mode picks the expected vote.
	task automatic vote(input logic [2:0] en, input int m);
		logic [31:0] a, b, c;
		a = $urandom;
		b = $urandom;
		c = $urandom;
		fork
			if (en[0]) u_ca.send(a);
			if (en[1]) u_cb.send(b);
			if (en[2]) u_cc.send(c);
		join
		case (m)
			0: last = (a & b) | (a & c) | (b & c);
			1: last = a | b;
			2: last = a & b;
			3: last = a;
		endcase
		if (m < 4)
			rd(`REG_VOTED, last, `RESP_OKAY, 1'b1);
	endtask
	// Each answer takes the oldest note at its handshake beat only, since
	// a held-off answer stands for several beats.
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			e = q.pop_front();
			chk("bresp", {30'h0, bresp}, {30'h0, e[33:32]});
		end
		if (rvalid && rready) begin
			e = q.pop_front();
			chk("rdata", rdata, e[31:0]);
			chk("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
			if (e[34])
				chk("load", load, e[31:0]);
		end
	end
	// A hang ends the run as a failure.
	initial begin
		repeat (4000) @(posedge aclk);
		fail_count++;
		stop_test();
	end
	// Main sequence.
	initial begin
		{aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		bready = 1'b1;
		rready = 1'b1;
		void'($urandom(6));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`REG_CTRL, `CTRL_RESET);
		rd(`REG_DEFAULT, `DEFAULT_RESET);
		rd(`REG_TIMEOUT, TMO);
		rd(`REG_ID, `ID_VALUE);
		rd(`REG_STATUS, 32'h0000_0000);
		rd(12'h100, 32'h0000_0000, `RESP_SLVERR);
		wr(`REG_VOTED, 32'h0000_0000, `RESP_SLVERR);
		wr(`REG_CTRL, 32'h0000_0071);
		vote(3'b111, 0);
		wr(`REG_CTRL, 32'h0000_0001);
		repeat (3) vote(3'b111, 0);
		wr(`REG_CTRL, 32'h0000_0003);
		repeat (3) vote(3'b111, 0);
		rd(`REG_STATUS, 32'h0000_003f);
		// C falls silent, as after a lone-survivor shutdown.
		repeat (10) vote(3'b011, 4);
		rd(`REG_STATUS, 32'h0000_001b);
		repeat (3) vote(3'b011, 1);
		wr(`REG_CTRL, 32'h0000_0001);
		repeat (3) vote(3'b011, 2);
		repeat (10) vote(3'b001, 4);
		rd(`REG_STATUS, 32'h0000_0009);
		wr(`REG_CTRL, 32'h0000_0003);
		repeat (3) vote(3'b001, 3);
		dflt = $urandom;
		wr(`REG_DEFAULT, dflt);
		wr(`REG_CTRL, 32'h0000_0005);
		vote(3'b001, 3);
		repeat (TMO + 10) @(posedge aclk);
		rd(`REG_VOTED, last, `RESP_OKAY, 1'b1);
		wr(`REG_CTRL, 32'h0000_0001);
		rd(`REG_VOTED, dflt, `RESP_OKAY, 1'b1);
		u_ca.send(~dflt);
		rd(`REG_STATUS, 32'h0000_0001);
		rd(`REG_VOTED, dflt, `RESP_OKAY, 1'b1);
		u_ca.send(dflt);
		rd(`REG_STATUS, 32'h0000_0009);
		vote(3'b001, 3);
		wr(`REG_CTRL, 32'h0000_0000);
		vote(3'b111, 3);
		stop_test();
	end
endmodule
`default_nettype wire
